//--- core/smt_opmode_timing.sv
// operating mode and timing status part of a static memory controller
// assumes a plain register port: one-cycle strobes, read data next cycle
// Notes on behaviour
// - written mode and cycle values only apply after an update command
// - mode bit 11 set enables the address latch strobe
// - burst field bits 5..3: 000 single beat, 001 four beats, rest reserved
// - width field bits 1..0: 01 selects 16-bit bus, rest reserved
// - status bits 19..17 report turnaround, codes 1..7 memctl clocks
// - status bits 13..11 write pulse, 10..8 output enable delay, 1..7
// - status bits 7..4 report write cycle, codes 3..15
// - status bits 3..0 report read cycle, codes 2..15
// - update command is command type 10 plus chip select; others refused
// - timing counts are memctl clocks, half the system clock rate
//
// The plain strobed port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module smt_opmode_timing
	import smt_pkg::*;
(
	input  wire logic                 clock,
	input  wire logic                 resetn,
	input  wire logic [ADDR_W-1:0]    regAddr,
	input  wire logic [DATA_W-1:0]    regWriteData,
	input  wire logic                 regWrite,
	input  wire logic                 regRead,
	output logic      [DATA_W-1:0]    regReadData,
	output logic                      aleEnable,
	output logic                      burstFour,
	output logic                      width16,
	output logic      [1:0]           committedCs,
	output logic      [SYS_CYC_W-1:0] turnaroundSysClocks,
	output logic      [SYS_CYC_W-1:0] writePulseSysClocks,
	output logic      [SYS_CYC_W-1:0] oeDelaySysClocks,
	output logic      [SYS_CYC_W-1:0] writeCycleSysClocks,
	output logic      [SYS_CYC_W-1:0] readCycleSysClocks,
	output logic                      memctlTick,
	output logic                      updateDone
);

	// pending (written, not yet applied) settings
	logic [TIMING_W-1:0] pendTiming;
	logic                pendAdv;
	logic [BL_W-1:0]     pendBurst;
	logic [MW_W-1:0]     pendWidth;

	// committed word of the chip select updated last
	logic [MEM_W-1:0]    activeWord;
	logic [NUM_CS-1:0]   csWritten;
	logic [ERR_W-1:0]    errFlags;
	logic                memctlPhase;

	// read pipeline
	logic                readFromStore;
	logic                readWritten;
	logic [DATA_W-1:0]   readHeld;
	logic [MEM_W-1:0]    storeData;

	// decode
	wire hitCmd     = regAddr == OFS_DIRECT_CMD;
	wire hitCycles  = regAddr == OFS_SET_CYCLES;
	wire hitOpmode  = regAddr == OFS_SET_OPMODE;
	wire hitStatus0 = regAddr == OFS_TIMING_STATUS_0;
	wire hitStatus1 = regAddr == OFS_TIMING_STATUS_1;
	wire hitStatus2 = regAddr == OFS_TIMING_STATUS_2;
	wire hitStatus3 = regAddr == OFS_TIMING_STATUS_3;
	wire hitMode    = regAddr == OFS_MODE_STATUS;
	wire hitError   = regAddr == OFS_ERROR_STATUS;
	wire hitStatus  = hitStatus0 | hitStatus1 | hitStatus2 | hitStatus3;

	wire [1:0] statusCs = hitStatus1 ? 2'h1 : hitStatus2 ? 2'h2 : hitStatus3 ? 2'h3 : 2'h0;

	// direct command fields
	wire [CMD_CS_W-1:0]   cmdCs      = regWriteData[CMD_CS_LSB +: CMD_CS_W];
	wire [CMD_TYPE_W-1:0] cmdType    = regWriteData[CMD_TYPE_LSB +: CMD_TYPE_W];
	wire                  cmdWrite   = regWrite & hitCmd;
	wire                  typeOk     = cmdType == CMD_TYPE_UPDATE;
	wire                  csOk       = cmdCs < CMD_CS_W'(NUM_CS);
	wire                  timingOk   = smt_timing_legal(pendTiming);
	wire                  modeOk     = ((pendBurst == BL_SINGLE) | (pendBurst == BL_FOUR))
		& (pendWidth == MW_16);
	// a refused command leaves every committed value untouched
	wire                  doUpdate   = cmdWrite & typeOk & csOk & timingOk & modeOk;

	wire [MEM_W-1:0] pendWord = {pendAdv, pendBurst, pendWidth, pendTiming};

	// error events; a clear-by-write-one loses to a new event
	wire [ERR_W-1:0] errEvent;
	assign errEvent[ERR_CMD_TYPE] = cmdWrite & ~typeOk;
	assign errEvent[ERR_CS]       = cmdWrite & typeOk & ~csOk;
	assign errEvent[ERR_TIMING]   = cmdWrite & typeOk & csOk & ~timingOk;
	assign errEvent[ERR_MODE]     = cmdWrite & typeOk & csOk & timingOk & ~modeOk;
	wire [ERR_W-1:0] errClear = (regWrite & hitError) ? regWriteData[ERR_W-1:0] : '0;
	wire [ERR_W-1:0] next_errFlags = (errFlags & ~errClear) | errEvent;

	// committed fields of the active word
	wire [TIMING_W-1:0] actTiming = activeWord[TIMING_W-1:0];
	wire [MW_W-1:0]     actWidth  = activeWord[TIMING_W +: MW_W];
	wire [BL_W-1:0]     actBurst  = activeWord[TIMING_W+MW_W +: BL_W];
	wire                actAdv    = activeWord[MEM_W-1];

	// store read: status word, or reset value if this chip select never updated
	wire [TIMING_W-1:0] storeTiming = readWritten ? storeData[TIMING_W-1:0] : TIMING_RESET;
	wire [DATA_W-1:0]   storeStatus = DATA_W'(storeTiming & TIMING_MASK);

	// immediate read value for registers held in flops
	wire [DATA_W-1:0] modeWord = DATA_W'({actAdv, 5'h00, actBurst, 1'b0, actWidth});
	wire [DATA_W-1:0] next_readHeld =
		hitMode  ? modeWord :
		hitError ? DATA_W'(errFlags) :
		'0;

	smt_cs_store #(
		.WIDTH (MEM_W),
		.DEPTH (NUM_CS),
		.AW    (2)
	) u_store (
		.clock       (clock),
		.writeEnable (doUpdate),
		.writeAddr   (cmdCs[1:0]),
		.writeData   (pendWord),
		.readAddr    (statusCs),
		.readData    (storeData)
	);

	// pending registers take software writes without any effect yet
	always_ff @(posedge clock)
	begin
		if (!resetn)
		begin
			pendTiming <= TIMING_RESET;
			pendAdv    <= 1'b1;
			pendBurst  <= BL_SINGLE;
			pendWidth  <= MW_16;
		end
		else
		begin
			if (regWrite & hitCycles)
				pendTiming <= regWriteData[TIMING_W-1:0] & TIMING_MASK;
			if (regWrite & hitOpmode)
			begin
				pendAdv   <= regWriteData[ADV_BIT];
				pendBurst <= regWriteData[BL_LSB +: BL_W];
				pendWidth <= regWriteData[MW_LSB +: MW_W];
			end
		end
	end

	// commit on the update command only
	always_ff @(posedge clock)
	begin
		if (!resetn)
		begin
			activeWord  <= {1'b1, BL_SINGLE, MW_16, TIMING_RESET};
			committedCs <= 2'h0;
			csWritten   <= '0;
			updateDone  <= 1'b0;
		end
		else
		begin
			updateDone <= doUpdate;
			if (doUpdate)
			begin
				activeWord          <= pendWord;
				committedCs         <= cmdCs[1:0];
				csWritten[cmdCs[1:0]] <= 1'b1;
			end
		end
	end

	always_ff @(posedge clock)
	begin
		if (!resetn)
			errFlags <= '0;
		else
			errFlags <= next_errFlags;
	end

	// memctl clock phase: one tick every MEMCTL_DIV system clocks
	always_ff @(posedge clock)
	begin
		if (!resetn)
		begin
			memctlPhase <= 1'b0;
			memctlTick  <= 1'b0;
		end
		else
		begin
			memctlPhase <= ~memctlPhase;
			// follows the new phase, so the tick alternates from the first edge after reset
			memctlTick  <= ~memctlPhase;
		end
	end

	// committed mode and timing, expressed in system clocks for the bus engine
	always_ff @(posedge clock)
	begin
		if (!resetn)
		begin
			aleEnable           <= 1'b1;
			burstFour           <= 1'b0;
			width16             <= 1'b1;
			turnaroundSysClocks <= smt_sys_cycles({1'b0, TIMING_RESET[TR_LSB +: SHORT_W]});
			writePulseSysClocks <= smt_sys_cycles({1'b0, TIMING_RESET[WP_LSB +: SHORT_W]});
			oeDelaySysClocks    <= smt_sys_cycles({1'b0, TIMING_RESET[CEOE_LSB +: SHORT_W]});
			writeCycleSysClocks <= smt_sys_cycles(TIMING_RESET[WC_LSB +: LONG_W]);
			readCycleSysClocks  <= smt_sys_cycles(TIMING_RESET[RC_LSB +: LONG_W]);
		end
		else
		begin
			aleEnable           <= actAdv;
			burstFour           <= actBurst == BL_FOUR;
			width16             <= actWidth == MW_16;
			turnaroundSysClocks <= smt_sys_cycles({1'b0, actTiming[TR_LSB +: SHORT_W]});
			writePulseSysClocks <= smt_sys_cycles({1'b0, actTiming[WP_LSB +: SHORT_W]});
			oeDelaySysClocks    <= smt_sys_cycles({1'b0, actTiming[CEOE_LSB +: SHORT_W]});
			writeCycleSysClocks <= smt_sys_cycles(actTiming[WC_LSB +: LONG_W]);
			readCycleSysClocks  <= smt_sys_cycles(actTiming[RC_LSB +: LONG_W]);
		end
	end

	// read pipeline: store data and held data both land one clock later
	always_ff @(posedge clock)
	begin
		if (!resetn)
		begin
			readFromStore <= 1'b0;
			readWritten   <= 1'b0;
			readHeld      <= '0;
		end
		else
		begin
			readFromStore <= regRead & hitStatus;
			// taken with the store read, so a same-cycle first update still reads the old value
			readWritten   <= csWritten[statusCs];
			readHeld      <= regRead ? next_readHeld : '0;
		end
	end

	// status fields keep their documented positions; reserved bits read zero
	assign regReadData = readFromStore ? storeStatus : readHeld;

endmodule
`default_nettype wire

//--- core/smt_pkg.sv
// constants shared by the static memory mode and timing status block
// assumes a 32-bit register port with byte offsets on an 8-bit address
package smt_pkg;

	localparam int DATA_W = 32;
	localparam int ADDR_W = 8;

	// register byte offsets
	localparam logic [ADDR_W-1:0] OFS_DIRECT_CMD      = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_SET_CYCLES      = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_SET_OPMODE      = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_TIMING_STATUS_0 = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_TIMING_STATUS_1 = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_TIMING_STATUS_2 = 8'h18;
	localparam logic [ADDR_W-1:0] OFS_TIMING_STATUS_3 = 8'h1c;
	localparam logic [ADDR_W-1:0] OFS_MODE_STATUS     = 8'h20;
	localparam logic [ADDR_W-1:0] OFS_ERROR_STATUS    = 8'h24;

	// direct command fields
	localparam int              CMD_CS_LSB      = 23;
	localparam int              CMD_CS_W        = 3;
	localparam int              CMD_TYPE_LSB    = 21;
	localparam int              CMD_TYPE_W      = 2;
	localparam logic [1:0]      CMD_TYPE_UPDATE = 2'h2;
	localparam int              NUM_CS          = 4;

	// operating mode fields
	localparam int              ADV_BIT   = 11;
	localparam int              BL_LSB    = 3;
	localparam int              BL_W      = 3;
	localparam int              MW_LSB    = 0;
	localparam int              MW_W      = 2;
	localparam logic [2:0]      BL_SINGLE = 3'h0;
	localparam logic [2:0]      BL_FOUR   = 3'h1;
	localparam logic [1:0]      MW_16     = 2'h1;

	// timing fields, shared by the cycle setting and status layouts
	localparam int              TR_LSB   = 17;
	localparam int              WP_LSB   = 11;
	localparam int              CEOE_LSB = 8;
	localparam int              WC_LSB   = 4;
	localparam int              RC_LSB   = 0;
	localparam int              SHORT_W  = 3;
	localparam int              LONG_W   = 4;
	localparam int              TIMING_W = 20;
	localparam logic [19:0]     TIMING_MASK  = 20'he3fff;
	localparam logic [19:0]     TIMING_RESET = 20'h233c6;
	localparam logic [2:0]      SHORT_MIN    = 3'h1;
	localparam logic [3:0]      WC_MIN       = 4'h3;
	localparam logic [3:0]      RC_MIN       = 4'h2;

	// memctl_clock runs at the system clock divided by this
	localparam int              MEMCTL_DIV = 2;
	localparam int              SYS_CYC_W  = 5;

	// stored word per chip select: {adv, burst, width, timing}
	localparam int              MEM_W = 1 + BL_W + MW_W + TIMING_W;

	// error status bits
	localparam int              ERR_CMD_TYPE = 0;
	localparam int              ERR_CS       = 1;
	localparam int              ERR_TIMING   = 2;
	localparam int              ERR_MODE     = 3;
	localparam int              ERR_W        = 4;

	function automatic logic [SYS_CYC_W-1:0] smt_sys_cycles(input logic [LONG_W-1:0] code);
		smt_sys_cycles = SYS_CYC_W'(code * MEMCTL_DIV);
	endfunction

	function automatic logic smt_timing_legal(input logic [TIMING_W-1:0] t);
		smt_timing_legal = (t[TR_LSB +: SHORT_W] >= SHORT_MIN)
			&& (t[WP_LSB +: SHORT_W] >= SHORT_MIN)
			&& (t[CEOE_LSB +: SHORT_W] >= SHORT_MIN)
			&& (t[WC_LSB +: LONG_W] >= WC_MIN)
			&& (t[RC_LSB +: LONG_W] >= RC_MIN);
	endfunction

endpackage

//--- core/smt_cs_store.sv
// small per chip select store of committed mode and timing words
// one write port, one read port; read data is registered, so it
// appears one clock after the read address; a write and a read of
// the same entry in one cycle return the old word
`timescale 1ns/1ps
`default_nettype none
module smt_cs_store #(
	parameter int WIDTH = 26,
	parameter int DEPTH = 4,
	parameter int AW    = 2
) (
	input  wire logic             clock,
	input  wire logic             writeEnable,
	input  wire logic [AW-1:0]    writeAddr,
	input  wire logic [WIDTH-1:0] writeData,
	input  wire logic [AW-1:0]    readAddr,
	output logic      [WIDTH-1:0] readData
);

	logic [WIDTH-1:0] words [DEPTH];

	always_ff @(posedge clock)
	begin
		if (writeEnable)
			words[writeAddr] <= writeData;
		readData <= words[readAddr];
	end

endmodule
`default_nettype wire

//--- tb/smt_chk.sv
// checker for the mode and timing status block
// bound to the top module, sees its ports only
`timescale 1ns/1ps
`default_nettype none
module smt_chk
	import smt_pkg::*;
(
	input wire logic                 clock,
	input wire logic                 resetn,
	input wire logic [ADDR_W-1:0]    regAddr,
	input wire logic [DATA_W-1:0]    regWriteData,
	input wire logic                 regWrite,
	input wire logic                 regRead,
	input wire logic [DATA_W-1:0]    regReadData,
	input wire logic                 aleEnable,
	input wire logic                 burstFour,
	input wire logic                 width16,
	input wire logic [1:0]           committedCs,
	input wire logic [SYS_CYC_W-1:0] turnaroundSysClocks,
	input wire logic [SYS_CYC_W-1:0] writePulseSysClocks,
	input wire logic [SYS_CYC_W-1:0] oeDelaySysClocks,
	input wire logic [SYS_CYC_W-1:0] writeCycleSysClocks,
	input wire logic [SYS_CYC_W-1:0] readCycleSysClocks,
	input wire logic                 memctlTick,
	input wire logic                 updateDone
);
	logic rstSeen;
	// one edge of grace after reset release, before outputs have left their reset state
	always_ff @(posedge clock)
		rstSeen <= resetn;
	default clocking @(posedge clock); endclocking
	default disable iff (!resetn || !rstSeen);
	sequence updWr;
		regWrite && regAddr == OFS_DIRECT_CMD && regWriteData[22:21] == CMD_TYPE_UPDATE;
	endsequence
	sequence statRd;
		regRead && regAddr[7:4] == 4'h1 && regAddr[1:0] == 2'h0;
	endsequence
	a_tick_falls: assert property (memctlTick |=> !memctlTick)
		else $error("memctl tick held high");
	a_tick_rises: assert property (!memctlTick |=> memctlTick)
		else $error("memctl tick held low");
	a_done_single: assert property (updateDone |=> !updateDone)
		else $error("update pulse too long");
	a_done_cause: assert property (updateDone |-> $past(regWrite && regAddr == OFS_DIRECT_CMD
		&& regWriteData[22:21] == CMD_TYPE_UPDATE)) else $error("update without command");
	a_commit_hold: assert property ($changed({aleEnable, burstFour, width16, turnaroundSysClocks,
		writePulseSysClocks, oeDelaySysClocks, writeCycleSysClocks, readCycleSysClocks})
		|-> $past(updateDone)) else $error("setting applied without update");
	a_tr_range: assert property (turnaroundSysClocks inside {[2:14]} && !turnaroundSysClocks[0])
		else $error("turnaround out of range");
	a_wp_oe_range: assert property (writePulseSysClocks inside {[2:14]}
		&& oeDelaySysClocks inside {[2:14]}) else $error("pulse or delay out of range");
	a_wc_range: assert property (writeCycleSysClocks inside {[6:30]})
		else $error("write cycle out of range");
	a_rc_range: assert property (readCycleSysClocks inside {[4:30]})
		else $error("read cycle out of range");
	a_stat_resv: assert property (statRd |=> (regReadData & 32'hfff1c000) == 32'h0)
		else $error("status reserved bits set");
	a_done_follow: assert property (updWr ##1 updateDone |-> committedCs
		== $past(regWriteData[24:23])) else $error("update committed to wrong chip select");
	a_cs_refused: assert property (updWr ##0 regWriteData[25] |=> !updateDone)
		else $error("update to missing chip select accepted");
	a_mode_match: assert property (regRead && regAddr == OFS_MODE_STATUS && !updateDone
		&& !(regWrite && regAddr == OFS_DIRECT_CMD) |=> regReadData[11] == aleEnable
		&& regReadData[3] == burstFour && regReadData[0] == width16) else $error("mode mismatch");
endmodule
bind smt_opmode_timing smt_chk i_chk (.clock, .resetn, .regAddr, .regWriteData, .regWrite,
	.regRead, .regReadData, .aleEnable, .burstFour, .width16, .committedCs,
	.turnaroundSysClocks, .writePulseSysClocks, .oeDelaySysClocks, .writeCycleSysClocks,
	.readCycleSysClocks, .memctlTick, .updateDone);
`default_nettype wire

//--- tb/smt_mem_model.sv
// stand-in for the external static memory
// counts the memctl cycles it is clocked by while the address latch strobe is enabled
`timescale 1ns/1ps
`default_nettype none
module smt_mem_model (
	input  wire logic        clock,
	input  wire logic        resetn,
	input  wire logic        memctlTick,
	input  wire logic        aleEnable,
	output logic      [15:0] tickCount
);
	// the memory sees one cycle per tick, half the system rate
	always_ff @(posedge clock)
		if (!resetn)
			tickCount <= '0;
		else if (memctlTick && aleEnable)
			tickCount <= tickCount + 16'h1;
endmodule
`default_nettype wire

//--- tb/smt_opmode_timing_bench.sv
// self-checking bench for the mode and timing status block
// drives the register port, notes expected read values in a queue
`timescale 1ns/1ps
`default_nettype none
module smt_opmode_timing_bench import smt_pkg::*;;
	logic                 clock = 0, resetn = 0, regWrite = 0, regRead = 0, rdPend = 0;
	logic [7:0]           regAddr = '0;
	logic [31:0]          regWriteData = '0, regReadData;
	logic                 aleEnable, burstFour, width16, memctlTick, updateDone;
	logic [1:0]           committedCs;
	logic [4:0]           trSys, wpSys, oeSys, wcSys, rcSys;
	logic [15:0]          tickCount, tc0;
	logic [31:0]          expQ[$];
	logic [19:0]          stat[4], bad[5];
	int                   failures = 0, num_checks = 0, cycles = 0, seed = 49608;
	smt_opmode_timing i_dut (.clock, .resetn, .regAddr, .regWriteData, .regWrite, .regRead,
		.regReadData, .aleEnable, .burstFour, .width16, .committedCs,
		.turnaroundSysClocks(trSys), .writePulseSysClocks(wpSys), .oeDelaySysClocks(oeSys),
		.writeCycleSysClocks(wcSys), .readCycleSysClocks(rcSys), .memctlTick, .updateDone);
	smt_mem_model i_mem (.clock, .resetn, .memctlTick, .aleEnable, .tickCount);
	always #20 clock = ~clock;
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			failures++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		regWrite <= w;
		regRead <= r;
		regAddr <= a;
		regWriteData <= d;
		if (r)
			expQ.push_back(d);
	endtask
	task automatic idle(input int n);
		repeat (n) bus(0, 0, 8'h0, 32'h0);
	endtask
	// pending is refused unless ok, and the error flag word then reads bit errBit alone
	task automatic upd(input int cs, input logic [1:0] ty, input logic ok, input int errBit);
		bus(1, 0, OFS_DIRECT_CMD, (32'(cs) << 23) | (32'(ty) << 21));
		idle(1);
		#1 chk(32'(updateDone), 32'(ok));
		if (!ok)
		begin
			bus(0, 1, OFS_ERROR_STATUS, 32'h1 << errBit);
			bus(1, 0, OFS_ERROR_STATUS, 32'hf);
		end
		idle(1);
	endtask
	task automatic rstchk();
		foreach (stat[i])
			bus(0, 1, OFS_TIMING_STATUS_0 + 8'(4 * i), 32'h233c6);
		bus(0, 1, OFS_SET_OPMODE, 32'h0);
		bus(0, 1, 8'hfc, 32'h0);
		idle(2);
		#1 chk({aleEnable, burstFour, width16, trSys, wpSys, oeSys, wcSys, rcSys, committedCs},
			{3'b101, 5'd2, 5'd12, 5'd6, 5'd24, 5'd12, 2'd0});
		$display("test reset values done");
	endtask
	function automatic logic [3:0] rnd(input int lo, input int hi);
		return 4'(lo + $unsigned($random(seed)) % (hi - lo + 1));
	endfunction
	task automatic commit(input int cs);
		logic [19:0] t;
		logic [31:0] m;
		t = {3'(rnd(1, 7)), 3'h0, 3'(rnd(1, 7)), 3'(rnd(1, 7)), rnd(3, 15), rnd(2, 15)};
		m = 32'h801 | (32'($random(seed) & 1) << 3);
		bus(1, 0, OFS_SET_CYCLES, 32'(t));
		bus(1, 0, OFS_SET_OPMODE, m);
		bus(0, 1, OFS_TIMING_STATUS_0 + 8'(4 * cs), 32'(stat[cs]));
		upd(cs, 2'h2, 1, 0);
		stat[cs] = t;
		#1 chk({burstFour, committedCs, trSys, wpSys, oeSys}, {m[3], 2'(cs),
			{1'b0, t[19:17], 1'b0}, {1'b0, t[13:11], 1'b0}, {1'b0, t[10:8], 1'b0}});
		chk({aleEnable, width16, wcSys, rcSys}, {2'b11, {t[7:4], 1'b0}, {t[3:0], 1'b0}});
		bus(0, 1, OFS_TIMING_STATUS_0 + 8'(4 * cs), 32'(t));
		bus(0, 1, OFS_MODE_STATUS, m);
	endtask
	always @(posedge clock)
	begin
		if (rdPend)
			chk(regReadData, expQ.pop_front());
		rdPend <= regRead;
		cycles++;
		if (cycles == 3000)
		begin
			failures++;
			final_report();
		end
	end
	initial
	begin
		foreach (stat[i])
			stat[i] = 20'h233c6;
		bad = '{20'h033c6, 20'h203c6, 20'h230c6, 20'h23326, 20'h233c1};
		idle(5);
		resetn <= 1;
		rstchk();
		tc0 = tickCount;
		idle(20);
		#1 chk(32'(16'(tickCount - tc0)), 32'd10);
		for (int r = 0; r < 2; r++)
			foreach (stat[i])
				commit(i);
		bus(1, 0, OFS_TIMING_STATUS_0, $random(seed));
		$display("test commit done");
		foreach (bad[i])
		begin
			bus(1, 0, OFS_SET_CYCLES, 32'(bad[i]));
			upd(0, 2'h2, 0, 2);
		end
		bus(1, 0, OFS_SET_CYCLES, 32'h233c6);
		foreach (bad[i])
			if (i != 2)
				upd(1, 2'(i), 0, 0);
		upd(4, 2'h2, 0, 1);
		for (int i = 0; i < 4; i++)
		begin
			bus(1, 0, OFS_SET_OPMODE, i < 3 ? 32'h800 | 32'(i) << 1 : 32'h811);
			upd(2, 2'h2, 0, 3);
		end
		foreach (stat[i])
			bus(0, 1, OFS_TIMING_STATUS_0 + 8'(4 * i), 32'(stat[i]));
		$display("test refusals done");
		bus(0, 0, 8'h0, 32'h0);
		resetn <= 0;
		idle(5);
		resetn <= 1;
		rstchk();
		idle(3);
		final_report();
	end
endmodule
`default_nettype wire
